// ---- rtl/hall_drive_pkg.sv ----
// Shared constants for the hall commutation and drive-mode block.
// Assumes one 100 MHz system clock; all settings arrive as plain ports.
package hall_drive_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int CFG_W = 4;
	localparam logic [3:0] CFG_ALT_FIRST = 4'h6;
	localparam logic [3:0] CFG_ALT_LAST = 4'hb;
	localparam int ALT_TABLES = 6;
	localparam int CMD_W = 16;
	localparam int POS_W = 32;
	localparam int STEPS_W = 16;
	localparam logic [15:0] STEPS_MIN = 16'h0001;
	localparam logic [15:0] STEPS_RESET = 16'h00c8;
	localparam logic [31:0] ENC_RES_RESET = 32'h00000fa0;
	// Phase drive codes: bit1 = driven, bit0 = high side
	localparam logic [1:0] PH_OFF = 2'h0;
	localparam logic [1:0] PH_LOW = 2'h2;
	localparam logic [1:0] PH_HIGH = 2'h3;
	localparam int SINE_W = 8;
	typedef enum logic [1:0] {MODE_CURRENT, MODE_SPEED, MODE_POSITION, MODE_POS_SPEED} op_mode_e;
	typedef enum logic [1:0] {SRC_ANALOG, SRC_STEP_DIR, SRC_USB, SRC_CAN} cmd_src_e;
	typedef enum logic {COMM_TRAP, COMM_SINE} comm_e;
endpackage

// ---- rtl/hall_phase_table.sv ----
// Alternate hall-to-phase lookup for settings 6 to 11.
// Assumes the hall pattern is already synchronised; pure combinational.
`timescale 1ns/10ps
module hall_phase_table (
	input wire logic [2:0] hall_i,
	input wire logic [2:0] shift_i,
	output logic [5:0] phase_o,
	output logic valid_o
);
	logic [2:0] step;
	logic [3:0] idx;
	always_comb begin
		valid_o = 1'b1;
		step = 3'h0;
		unique case (hall_i)
			3'b001: step = 3'h0;
			3'b011: step = 3'h1;
			3'b010: step = 3'h2;
			3'b110: step = 3'h3;
			3'b100: step = 3'h4;
			3'b101: step = 3'h5;
			default: valid_o = 1'b0;
		endcase
		// Each setting advances one table row, which is a 60 degree shift
		idx = 4'(step) + 4'(shift_i);
		if (idx >= 4'h6) begin
			idx = idx - 4'h6;
		end
		// Row order of setting 6: AB AC BC BA CA CB (high/low)
		unique case (idx[2:0])
			3'h0: phase_o = {hall_drive_pkg::PH_HIGH, hall_drive_pkg::PH_LOW, hall_drive_pkg::PH_OFF};
			3'h1: phase_o = {hall_drive_pkg::PH_HIGH, hall_drive_pkg::PH_OFF, hall_drive_pkg::PH_LOW};
			3'h2: phase_o = {hall_drive_pkg::PH_OFF, hall_drive_pkg::PH_HIGH, hall_drive_pkg::PH_LOW};
			3'h3: phase_o = {hall_drive_pkg::PH_LOW, hall_drive_pkg::PH_HIGH, hall_drive_pkg::PH_OFF};
			3'h4: phase_o = {hall_drive_pkg::PH_LOW, hall_drive_pkg::PH_OFF, hall_drive_pkg::PH_HIGH};
			default: phase_o = {hall_drive_pkg::PH_OFF, hall_drive_pkg::PH_LOW, hall_drive_pkg::PH_HIGH};
		endcase
		if (!valid_o) begin
			phase_o = {hall_drive_pkg::PH_OFF, hall_drive_pkg::PH_OFF, hall_drive_pkg::PH_OFF};
		end
	end
endmodule

// ---- rtl/hall_drive_ctrl.sv ----
// Hall commutation and drive-mode control for a brushless motor stage.
// Assumes synchronous inputs on clk_sys_i; loop regulators sit outside and
// supply the torque demand; this block gates, signs and steers it.
// Behaviour
// - Settings 6 to 11 form one circular table, each step 60 degrees
// - Setting 6 maps hall rows to AB AC BC BA CA CB
// - Setting 7 maps hall rows to AC BC BA CA CB AB
// - Setting 8 maps hall rows to BC BA CA CB AB AC
// - Setting 9 maps hall rows to BA CA CB AB AC BC
// - Setting 10 maps hall rows to CA CB AB AC BC BA
// - Setting 11 maps hall rows to CB AB AC BC BA CA
// - Reverse spin swaps rotation without touching feedback polarity
// - Current mode regulates current only, speed loop idle
// - Speed mode holds speed by adjusting current
// - Step and direction source refused in current and speed modes
// - Position modes run their loops; commands apply at once, no ramp
// - Position modes need 4-quadrant and encoder feedback
// - Trapezoidal drives one phase high, one low, third floating
// - Sinusoidal drives all three phases together
// - 2-quadrant never brakes; 4-quadrant accelerates and brakes
// - With sync enabled, encoder count realigns on hall 1 edges
// - Source is analog, step/dir, USB or CAN; direction inverts analog
// - Drive runs only while enable input is asserted
// - One step per rising step edge; steps per rev from 1 to 65535
// - Step size is encoder resolution divided by steps per rev
// - Active limit inputs inhibit torque in their direction
// - Decoupled enable waits for command enable; else analog auto-enables
`timescale 1ns/10ps
module hall_drive_ctrl #(
	parameter int CMD_W = hall_drive_pkg::CMD_W,
	parameter int POS_W = hall_drive_pkg::POS_W
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [2:0] hall_i,
	input wire logic step_i,
	input wire logic dir_i,
	input wire logic enable_i,
	input wire logic limit_pos_i,
	input wire logic limit_neg_i,
	input wire logic [3:0] hall_cfg_i,
	input wire logic reverse_spin_i,
	input wire logic [1:0] op_mode_i,
	input wire logic [1:0] cmd_src_i,
	input wire logic comm_sine_i,
	input wire logic four_quad_i,
	input wire logic encoder_en_i,
	input wire logic enc_sync_i,
	input wire logic limits_en_i,
	input wire logic enable_decouple_i,
	input wire logic comm_enable_i,
	input wire logic comm_disable_i,
	input wire logic [15:0] steps_per_rev_i,
	input wire logic [31:0] enc_res_i,
	input wire logic signed [CMD_W-1:0] cmd_i,
	input wire logic signed [CMD_W-1:0] torque_dem_i,
	input wire logic [POS_W-1:0] enc_count_i,
	input wire logic [POS_W-1:0] hall1_align_i,
	input wire logic [7:0] elec_angle_i,
	output logic [5:0] phase_o,
	output logic [3*hall_drive_pkg::SINE_W-1:0] sine_duty_o,
	output logic drive_on_o,
	output logic cfg_err_o,
	output logic [1:0] loops_o,
	output logic signed [CMD_W-1:0] cmd_eff_o,
	output logic signed [POS_W-1:0] pos_target_o,
	output logic [POS_W-1:0] enc_count_o,
	output logic enc_resync_o
);
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [2:0] hall_prev_q;
	logic step_prev_q;
	logic comm_en_q;
	logic strap_done_q;
	logic cfg_ok;
	logic run;
	logic [2:0] tbl_shift;
	logic alt_sel;
	logic [5:0] tbl_phase;
	logic tbl_valid;
	logic signed [CMD_W-1:0] cmd_signed;
	logic signed [CMD_W-1:0] torque_d;
	logic [31:0] step_size_q;
	logic [31:0] div_rem_q;
	logic [31:0] div_quo_q;
	logic [5:0] div_cnt_q;
	logic [15:0] div_den_q;
	logic div_busy_q;
	logic [7:0] sa;
	logic [7:0] sb;
	logic [7:0] sc;
	logic edge_arm_q;
	logic prev_valid;
	logic step_ok_q;
	logic [5:0] tbl_swap;

	assign rst_n = rst_sync_q[1];

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	// Edges are ignored for one cycle, as the reset values of the copies are not real
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			hall_prev_q <= 3'h0;
			step_prev_q <= 1'b0;
			edge_arm_q <= 1'b0;
		end else begin
			hall_prev_q <= hall_i;
			step_prev_q <= step_i;
			edge_arm_q <= 1'b1;
		end
	end

	// A fault pattern before a hall 1 change is not a rotor edge
	always_comb begin
		prev_valid = hall_prev_q != 3'h0 && hall_prev_q != 3'h7;
	end

	// Configuration legality: illegal combos keep the stage off rather than guess
	always_comb begin
		cfg_ok = 1'b1;
		if ((op_mode_i == 2'(hall_drive_pkg::MODE_CURRENT) ||
			op_mode_i == 2'(hall_drive_pkg::MODE_SPEED)) &&
			cmd_src_i == 2'(hall_drive_pkg::SRC_STEP_DIR)) begin
			cfg_ok = 1'b0;
		end
		if ((op_mode_i == 2'(hall_drive_pkg::MODE_POSITION) ||
			op_mode_i == 2'(hall_drive_pkg::MODE_POS_SPEED)) &&
			(!four_quad_i || !encoder_en_i)) begin
			cfg_ok = 1'b0;
		end
		if (steps_per_rev_i < hall_drive_pkg::STEPS_MIN &&
			cmd_src_i == 2'(hall_drive_pkg::SRC_STEP_DIR)) begin
			cfg_ok = 1'b0;
		end
	end

	// Communication enable latch; the enable command wins over a disable
	// Auto-enable is tried once only, so a later source change never self-enables
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			comm_en_q <= 1'b0;
			strap_done_q <= 1'b0;
		end else begin
			strap_done_q <= 1'b1;
			if (comm_enable_i) begin
				comm_en_q <= 1'b1;
			end else if (comm_disable_i) begin
				comm_en_q <= 1'b0;
			end else if (!strap_done_q && !enable_decouple_i &&
				cmd_src_i == 2'(hall_drive_pkg::SRC_ANALOG)) begin
				comm_en_q <= 1'b1;
			end
		end
	end

	always_comb begin
		run = cfg_ok && enable_i && comm_en_q;
	end

	always_comb begin
		alt_sel = hall_cfg_i >= hall_drive_pkg::CFG_ALT_FIRST &&
			hall_cfg_i <= hall_drive_pkg::CFG_ALT_LAST;
		tbl_shift = alt_sel ? 3'(hall_cfg_i - hall_drive_pkg::CFG_ALT_FIRST) : 3'h0;
	end

	// Setting index selects the starting row
	hall_phase_table u_table (
		.hall_i(hall_i),
		.shift_i(tbl_shift),
		.phase_o(tbl_phase),
		.valid_o(tbl_valid)
	);

	// Command shaping: analog sign follows the direction input
	always_comb begin
		cmd_signed = cmd_i;
		if (cmd_src_i == 2'(hall_drive_pkg::SRC_ANALOG) && dir_i) begin
			cmd_signed = -cmd_i;
		end
	end

	// Torque demand after quadrant and limit gating
	always_comb begin
		torque_d = torque_dem_i;
		// In 2-quadrant mode braking demand (opposing command sign) is dropped
		// A zero command counts as forward, so only forward demand then passes
		if (!four_quad_i && (torque_dem_i[CMD_W-1] != cmd_signed[CMD_W-1])) begin
			torque_d = '0;
		end
		if (limits_en_i && limit_pos_i && !torque_d[CMD_W-1] && torque_d != '0) begin
			torque_d = '0;
		end
		if (limits_en_i && limit_neg_i && torque_d[CMD_W-1]) begin
			torque_d = '0;
		end
		// Reverse spin flips electrical direction only; feedback untouched
		if (reverse_spin_i) begin
			torque_d = -torque_d;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			cmd_eff_o <= '0;
			drive_on_o <= 1'b0;
			cfg_err_o <= 1'b0;
			loops_o <= 2'h0;
		end else begin
			cmd_eff_o <= run ? torque_d : '0;
			drive_on_o <= run;
			cfg_err_o <= !cfg_ok;
			// Loops active: 0 current, 1 speed+current, 2 pos+current, 3 all
			loops_o <= op_mode_i;
		end
	end

	// Reversed torque: every driven phase trades its high and low side
	always_comb begin
		tbl_swap = tbl_phase;
		for (int p = 0; p < 3; p++) begin
			if (tbl_phase[2*p+1]) begin
				tbl_swap[2*p] = ~tbl_phase[2*p];
			end
		end
	end

	// Phase outputs: block commutation or all-three sine duties
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			phase_o <= 6'h0;
		end else if (!run || !tbl_valid || torque_d == '0) begin
			phase_o <= 6'h0;
		end else if (comm_sine_i) begin
			phase_o <= {3{hall_drive_pkg::PH_HIGH}};
		end else if (torque_d[CMD_W-1]) begin
			phase_o <= tbl_swap;
		end else begin
			phase_o <= tbl_phase;
		end
	end

	// Coarse triangle-folded sine for the three 120-degree offset phases
	function automatic logic [7:0] wave(input logic [7:0] ang);
		logic [7:0] fold;
		fold = ang[7] ? ~ang : ang;
		return {fold[6:0], 1'b0};
	endfunction

	always_comb begin
		sa = wave(elec_angle_i);
		sb = wave(elec_angle_i - 8'h55);
		sc = wave(elec_angle_i - 8'haa);
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			sine_duty_o <= '0;
		// Duties drop to zero on any fault so the bridge never keeps a stale duty
		end else if (run && comm_sine_i && tbl_valid) begin
			sine_duty_o <= {sa, sb, sc};
		end else begin
			sine_duty_o <= '0;
		end
	end

	// Encoder resync on hall 1 edges, only while turning with sync on
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			enc_count_o <= '0;
			enc_resync_o <= 1'b0;
		end else if (enc_sync_i && encoder_en_i && run && edge_arm_q &&
			tbl_valid && prev_valid && (hall_i[2] != hall_prev_q[2])) begin
			enc_count_o <= hall1_align_i;
			enc_resync_o <= 1'b1;
		end else begin
			enc_count_o <= enc_count_i;
			enc_resync_o <= 1'b0;
		end
	end

	// Restoring divider: step size = resolution / steps per rev, truncated
	// A new steps-per-rev value takes effect up to 67 cycles later
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			div_busy_q <= 1'b0;
			div_cnt_q <= 6'h0;
			div_rem_q <= '0;
			div_quo_q <= '0;
			div_den_q <= hall_drive_pkg::STEPS_RESET;
			step_size_q <= '0;
			step_ok_q <= 1'b0;
		end else if (!div_busy_q) begin
			if (steps_per_rev_i != 16'h0) begin
				div_busy_q <= 1'b1;
				div_cnt_q <= 6'h20;
				div_rem_q <= '0;
				div_quo_q <= enc_res_i;
				div_den_q <= steps_per_rev_i;
			end
		end else if (div_cnt_q != 6'h0) begin
			if ({div_rem_q[30:0], div_quo_q[31]} >= {16'h0, div_den_q}) begin
				div_rem_q <= {div_rem_q[30:0], div_quo_q[31]} - {16'h0, div_den_q};
				div_quo_q <= {div_quo_q[30:0], 1'b1};
			end else begin
				div_rem_q <= {div_rem_q[30:0], div_quo_q[31]};
				div_quo_q <= {div_quo_q[30:0], 1'b0};
			end
			div_cnt_q <= div_cnt_q - 6'h1;
		end else begin
			step_size_q <= div_quo_q;
			step_ok_q <= 1'b1;
			div_busy_q <= 1'b0;
		end
	end

	// Step target moves at once on each rising step edge, no ramp
	// Steps that arrive before the first step size is known are dropped
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			pos_target_o <= '0;
		end else if (cmd_src_i == 2'(hall_drive_pkg::SRC_STEP_DIR) && run &&
			step_ok_q && edge_arm_q && step_i && !step_prev_q) begin
			if (dir_i) begin
				pos_target_o <= pos_target_o - $signed(POS_W'(step_size_q));
			end else begin
				pos_target_o <= pos_target_o + $signed(POS_W'(step_size_q));
			end
		end else if (cmd_src_i != 2'(hall_drive_pkg::SRC_STEP_DIR) &&
			op_mode_i[1]) begin
			pos_target_o <= POS_W'(cmd_signed);
		end
	end
endmodule

// ---- testbench/motor_hall_model.sv ----
// Hall sensor and encoder stand-in for the motor beyond the phase outputs.
// Assumes the bench picks the electrical sector and any sensor fault.
`timescale 1ns/10ps
module motor_hall_model (
	input wire logic clk_sys_i,
	input wire logic [2:0] sector_i,
	input wire logic [1:0] fault_i,
	output logic [2:0] hall_o,
	output logic [31:0] enc_o
);
	logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
	initial hall_o = 3'h1;
	initial enc_o = 32'h0;
	// Sensors settle one clock after the rotor enters a sector, as a real pickup lags
	always @(posedge clk_sys_i) begin
		hall_o <= (fault_i == 2'h1) ? 3'h0 : (fault_i == 2'h2) ? 3'h7 : seq[sector_i];
		enc_o <= enc_o + 32'h1;
	end
endmodule

// ---- testbench/hall_drive_ctrl_sva.sv ----
// Port-level checks of the hall commutation and drive-mode block.
// Assumes it is bound into hall_drive_ctrl; one clock domain.
`timescale 1ns/10ps
module hall_drive_ctrl_sva #(
	parameter int CMD_W = hall_drive_pkg::CMD_W,
	parameter int POS_W = hall_drive_pkg::POS_W
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [2:0] hall_i,
	input wire logic enable_i,
	input wire logic dir_i,
	input wire logic limit_pos_i,
	input wire logic limits_en_i,
	input wire logic four_quad_i,
	input wire logic encoder_en_i,
	input wire logic reverse_spin_i,
	input wire logic comm_sine_i,
	input wire logic enc_sync_i,
	input wire logic [1:0] op_mode_i,
	input wire logic [1:0] cmd_src_i,
	input wire logic signed [CMD_W-1:0] cmd_i,
	input wire logic [5:0] phase_o,
	input wire logic drive_on_o,
	input wire logic cfg_err_o,
	input wire logic [1:0] loops_o,
	input wire logic signed [CMD_W-1:0] cmd_eff_o,
	input wire logic enc_resync_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	logic [1:0] age_q;
	wire logic up = (age_q == 2'h3);
	wire logic [2:0] drv = {phase_o[5], phase_o[3], phase_o[1]};
	wire logic [2:0] hi = {phase_o[4], phase_o[2], phase_o[0]};
	wire logic bad_hall = (hall_i == 3'h0) || (hall_i == 3'h7);
	// Outputs stay cleared while the internal reset copy is still held
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i)
			age_q <= 2'h0;
		else if (age_q != 2'h3)
			age_q <= age_q + 2'h1;
	end
	chk_bad_hall_off: assert property (bad_hall |=> phase_o == 6'h00)
		else $error("phases driven on invalid hall");
	chk_trap_one_float: assert property ((up && !comm_sine_i) ##1
		(phase_o != 6'h00) |-> $countones(drv) == 2 && $countones(hi) == 1)
		else $error("trapezoidal pattern wrong");
	chk_sine_all_on: assert property ((up && comm_sine_i && !bad_hall) ##1
		(drive_on_o && cmd_eff_o != 0) |-> phase_o == 6'h3f)
		else $error("sine mode not driving all phases");
	chk_enable_gate: assert property (!enable_i |=> !drive_on_o)
		else $error("drive on without enable");
	chk_step_refused: assert property (up && cmd_src_i == 2'h1 && !op_mode_i[1] |=> cfg_err_o)
		else $error("step source accepted in current or speed");
	chk_pos_needs_4q: assert property (up && op_mode_i[1] &&
		!(four_quad_i && encoder_en_i) |=> cfg_err_o)
		else $error("position mode accepted without 4Q and encoder");
	chk_err_stops_drive: assert property (cfg_err_o |-> !drive_on_o && phase_o == 6'h00)
		else $error("drive active with bad config");
	chk_limit_pos_blk: assert property (up && limits_en_i && limit_pos_i &&
		!reverse_spin_i |=> cmd_eff_o <= 0)
		else $error("positive torque past limit");
	chk_two_quad_brake: assert property (up && !four_quad_i && !reverse_spin_i &&
		cmd_i > 0 && !(cmd_src_i == 2'h0 && dir_i) |=> cmd_eff_o >= 0)
		else $error("braking torque in 2-quadrant");
	chk_loops_follow: assert property (drive_on_o |-> loops_o == $past(op_mode_i))
		else $error("active loops differ from mode");
	chk_resync_pulse: assert property (enc_resync_o |-> $past(enc_sync_i) ##1 !enc_resync_o)
		else $error("resync pulse wrong");
	cov_resync: cover property (enc_resync_o);
	cov_cfg_err: cover property (cfg_err_o);
	cov_trap_drive: cover property (drive_on_o && phase_o != 6'h00 && !comm_sine_i);
endmodule

bind hall_drive_ctrl hall_drive_ctrl_sva #(.CMD_W(CMD_W), .POS_W(POS_W)) i_sva (
	.clk_sys_i, .nrst_i, .hall_i, .enable_i, .limit_pos_i, .limits_en_i, .four_quad_i,
	.encoder_en_i, .reverse_spin_i, .comm_sine_i, .enc_sync_i, .op_mode_i, .cmd_src_i,
	.cmd_i, .phase_o, .drive_on_o, .cfg_err_o, .loops_o, .cmd_eff_o, .enc_resync_o, .dir_i
);

// ---- testbench/hall_drive_ctrl_tb.sv ----
// Self-checking bench for the hall commutation and drive-mode block.
// Assumes the motor model supplies halls and encoder counts.
`timescale 1ns/10ps
module hall_drive_ctrl_tb;
	logic clk_sys_i = 1'b0, nrst_i = 1'b0, step_i = 1'b0, dir_i = 1'b0, enable_i = 1'b1;
	logic limit_pos_i = 1'b0, limit_neg_i = 1'b0, reverse_spin_i = 1'b0, comm_sine_i = 1'b0;
	logic four_quad_i = 1'b1, encoder_en_i = 1'b1, enc_sync_i = 1'b0, limits_en_i = 1'b0;
	logic enable_decouple_i = 1'b0, comm_enable_i = 1'b0, comm_disable_i = 1'b0;
	logic [3:0] hall_cfg_i = 4'h6;
	logic [1:0] op_mode_i = 2'h0, cmd_src_i = 2'h0, fault = 2'h0;
	logic [15:0] steps_per_rev_i = 16'h0004;
	logic [31:0] enc_res_i = 32'h00000fa0;
	logic signed [15:0] cmd_i = 16'sh0064, torque_dem_i = 16'sh0064;
	logic [2:0] sector = 3'h0, hall_i;
	logic [31:0] enc_count_i, enc_count_o, pos_target_o;
	logic [5:0] phase_o;
	logic [23:0] sine_duty_o;
	logic drive_on_o, cfg_err_o, enc_resync_o, seen;
	logic [1:0] loops_o;
	logic signed [15:0] cmd_eff_o;
	int mismatches = 0, n_tests = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	motor_hall_model i_motor (.clk_sys_i, .sector_i(sector), .fault_i(fault), .hall_o(hall_i),
		.enc_o(enc_count_i));
	hall_drive_ctrl i_dut (.clk_sys_i, .nrst_i, .hall_i, .step_i, .dir_i, .enable_i,
		.limit_pos_i, .limit_neg_i, .hall_cfg_i, .reverse_spin_i, .op_mode_i, .cmd_src_i,
		.comm_sine_i, .four_quad_i, .encoder_en_i, .enc_sync_i, .limits_en_i,
		.enable_decouple_i, .comm_enable_i, .comm_disable_i, .steps_per_rev_i, .enc_res_i,
		.cmd_i, .torque_dem_i, .enc_count_i, .hall1_align_i(32'h00001234),
		.elec_angle_i(8'h20), .phase_o, .sine_duty_o, .drive_on_o, .cfg_err_o, .loops_o,
		.cmd_eff_o, .pos_target_o, .enc_count_o, .enc_resync_o);
	task automatic tick(int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic check(string what, logic [31:0] got, logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		if (mismatches == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Pairs AB AC BC BA CA CB; three places on is the same pair reversed
	function automatic logic [5:0] pair_code(int k);
		logic [5:0] t [6] = '{6'h38, 6'h32, 6'h0e, 6'h2c, 6'h23, 6'h0b};
		return t[k % 6];
	endfunction
	task automatic set_eff(logic signed [15:0] t, logic [15:0] exp);
		torque_dem_i = t;
		tick(3);
		check("cmd_eff", {cmd_eff_o}, {16'h0000, exp});
	endtask
	initial begin
		tick(12);
		check("phase in reset", phase_o, 6'h00);
		nrst_i = 1'b1;
		tick(6);
		check("auto enable", drive_on_o, 1'b1);
		for (int c = 0; c < 6; c++) begin
			for (int r = 0; r < 12; r++) begin
				hall_cfg_i = 4'(6 + c);
				sector = 3'(r % 6);
				torque_dem_i = (r < 6) ? 16'sh0064 : -16'sh0064;
				tick(3);
				check("phase", phase_o, pair_code(r + c + 3 * (r / 6)));
			end
		end
		comm_sine_i = 1'b1;
		tick(3);
		check("sine phases", phase_o, 6'h3f);
		check("sine duty", {29'h0, sine_duty_o[23:16] != 8'h0, sine_duty_o[15:8] != 8'h0,
			sine_duty_o[7:0] != 8'h0}, 32'h7);
		comm_sine_i = 1'b0;
		for (int f = 1; f < 3; f++) begin
			fault = 2'(f);
			tick(3);
			check("invalid hall", phase_o, 6'h00);
		end
		fault = 2'h0;
		enable_i = 1'b0;
		tick(3);
		check("enable low", drive_on_o, 1'b0);
		enable_i = 1'b1;
		set_eff(16'sh0064, 16'h0064);
		op_mode_i = 2'h1;
		set_eff(16'sh0064, 16'h0064);
		check("loops", loops_o, 2'h1);
		reverse_spin_i = 1'b1;
		set_eff(16'sh0064, 16'hff9c);
		reverse_spin_i = 1'b0;
		limits_en_i = 1'b1;
		limit_pos_i = 1'b1;
		set_eff(16'sh0064, 16'h0000);
		set_eff(-16'sh0064, 16'hff9c);
		limit_pos_i = 1'b0;
		limit_neg_i = 1'b1;
		set_eff(-16'sh0064, 16'h0000);
		limits_en_i = 1'b0;
		limit_neg_i = 1'b0;
		four_quad_i = 1'b0;
		set_eff(-16'sh0064, 16'h0000);
		set_eff(16'sh0064, 16'h0064);
		dir_i = 1'b1;
		set_eff(16'sh0064, 16'h0000);
		set_eff(-16'sh0064, 16'hff9c);
		dir_i = 1'b0;
		cmd_src_i = 2'h1;
		op_mode_i = 2'h0;
		tick(3);
		check("step in current", cfg_err_o, 1'b1);
		check("refused drive", drive_on_o, 1'b0);
		cmd_src_i = 2'h2;
		op_mode_i = 2'h2;
		tick(3);
		check("position 2Q", cfg_err_o, 1'b1);
		four_quad_i = 1'b1;
		encoder_en_i = 1'b0;
		tick(3);
		check("position no encoder", cfg_err_o, 1'b1);
		encoder_en_i = 1'b1;
		cmd_i = -16'sh0005;
		tick(3);
		check("position ok", cfg_err_o, 1'b0);
		check("target", pos_target_o, 32'hfffffffb);
		op_mode_i = 2'h0;
		enc_sync_i = 1'b1;
		sector = 3'h2;
		tick(3);
		sector = 3'h3;
		for (int i = 0; i < 6 && enc_resync_o !== 1'b1; i++)
			tick(1);
		check("resync", enc_resync_o, 1'b1);
		check("resync count", enc_count_o, 32'h00001234);
		enc_sync_i = 1'b0;
		sector = 3'h1;
		seen = 1'b0;
		repeat (6) begin
			tick(1);
			seen = seen | enc_resync_o;
		end
		check("no resync", seen, 1'b0);
		check("count follows", enc_count_o, enc_count_i - 32'h1);
		enable_decouple_i = 1'b1;
		cmd_src_i = 2'h1;
		op_mode_i = 2'h2;
		nrst_i = 1'b0;
		tick(2);
		nrst_i = 1'b1;
		tick(8);
		check("decoupled off", drive_on_o, 1'b0);
		comm_enable_i = 1'b1;
		tick(1);
		comm_enable_i = 1'b0;
		tick(40);
		check("command enable", drive_on_o, 1'b1);
		check("target start", pos_target_o, 32'h00000000);
		for (int s = 0; s < 4; s++) begin
			dir_i = (s == 3);
			step_i = 1'b1;
			tick(1);
			step_i = 1'b0;
			tick(3);
			if (s == 2)
				check("three steps", pos_target_o, 32'h00000bb8);
		end
		check("step back", pos_target_o, 32'h000007d0);
		steps_per_rev_i = 16'h0000;
		tick(3);
		check("zero steps", cfg_err_o, 1'b1);
		steps_per_rev_i = 16'h0004;
		comm_disable_i = 1'b1;
		tick(1);
		comm_disable_i = 1'b0;
		tick(3);
		check("command disable", drive_on_o, 1'b0);
		tally_and_finish();
	end
	initial begin
		#100us;
		mismatches++;
		tally_and_finish();
	end
endmodule
